/* File: design/lvm_pkg.sv */
// package for the local-to-vme map attribute block: offsets, fields, resets, modifier codes
package lvm_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0] LVM_OFS_START1 = 8'h14;
  localparam logic [7:0] LVM_OFS_START2 = 8'h18;
  localparam logic [7:0] LVM_OFS_START3 = 8'h1C;
  localparam logic [7:0] LVM_OFS_START4 = 8'h20;
  localparam logic [7:0] LVM_OFS_XLAT4 = 8'h24;
  localparam logic [7:0] LVM_OFS_ATTR = 8'h28;
  localparam logic [7:0] LVM_OFS_CTRL = 8'h2C;
  // attribute byte layout
  localparam int LVM_ATTR_NARROW = 7;
  localparam int LVM_ATTR_POST = 6;
  // control word field positions
  localparam int LVM_GRP_LSB = 24;
  localparam int LVM_BRD_LSB = 20;
  localparam int LVM_EN_LSB = 16;
  localparam int LVM_IO_LSB = 8;
  localparam int LVM_SS_PRIV = 8;
  localparam int LVM_SS_POST = 9;
  localparam int LVM_SS_NARROW = 10;
  localparam int LVM_SS_ON = 11;
  localparam int LVM_FP_PD = 12;
  localparam int LVM_FP_PRIV = 13;
  localparam int LVM_FP_POST = 14;
  localparam int LVM_FP_ON = 15;
  // reset values
  localparam logic [31:0] LVM_ATTR_RST = 32'h0000_0000;
  localparam logic [7:0] LVM_GRP_RST = 8'h00;
  localparam logic [3:0] LVM_BRD_RST = 4'hF;
  localparam logic [3:0] LVM_BRD_OFF = 4'hF;
  localparam logic [3:0] LVM_EN_RST = 4'h0;
  localparam logic [7:0] LVM_IO_RST = 8'h00;
  localparam logic [31:0] LVM_MAP_RST = 32'h0000_0000;
  // fixed windows
  localparam logic [15:0] LVM_SS_PAGE = 16'hFFFF;
  localparam logic [3:0] LVM_FP_NIB = 4'hF;
  localparam logic [7:0] LVM_FP_A24 = 8'hF0;
  localparam logic [7:0] LVM_FP_TOP = 8'hFF;
  localparam logic [3:0] LVM_LM_NIB = 4'hF;
  // standard modifier codes
  localparam logic [5:0] LVM_AM_A16_SUP = 6'h2D;
  localparam logic [5:0] LVM_AM_A16_USR = 6'h29;
  localparam logic [5:0] LVM_AM_A24_SP = 6'h3E;
  localparam logic [5:0] LVM_AM_A24_SD = 6'h3D;
  localparam logic [5:0] LVM_AM_A24_UP = 6'h3A;
  localparam logic [5:0] LVM_AM_A24_UD = 6'h39;
  localparam logic [5:0] LVM_AM_A32_SP = 6'h0E;
  localparam logic [5:0] LVM_AM_A32_SD = 6'h0D;
  localparam logic [5:0] LVM_AM_A32_UP = 6'h0A;
  localparam logic [5:0] LVM_AM_A32_UD = 6'h09;

  // local request toward the map
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } lvm_req_t;

  // decision for the vme master
  typedef struct packed {
    logic go;
    logic [5:0] modifier_code_field;
    logic narrow;
    logic posted;
    logic [31:0] vme_addr;
    logic conflict;
  } lvm_cyc_t;

  // slave-side csr decode toward the vme slave logic
  typedef struct packed {
    logic csr_hit;
    logic [3:0] lm_hit;
  } lvm_slv_t;
endpackage

/* File: design/lvm_map.sv */
// local-to-vme map decoders with their attribute, enable and i/o-map control registers
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module lvm_map (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // local access in, vme cycle out
  input wire lvm_pkg::lvm_req_t local_req,
  output lvm_pkg::lvm_cyc_t vme_cyc,
  // vme slave side address and ownership
  input wire logic [15:0] vme_slv_addr,
  input wire logic vme_slv_short,
  input wire logic vme_owned,
  output lvm_pkg::lvm_slv_t slv_dec,
  output logic ctrl_change_unowned
);
  import lvm_pkg::*;

  logic [31:0] start_end_ff [4];
  logic [31:0] nxt_start_end [4];
  logic [31:0] xlat_ff, nxt_xlat;
  logic [31:0] attr_ff, nxt_attr;
  logic [7:0] grp_ff, nxt_grp;
  logic [3:0] brd_ff, nxt_brd;
  logic [3:0] en_ff, nxt_en;
  logic [7:0] io_ff, nxt_io;
  logic [31:0] rdata_ff, nxt_rdata;
  lvm_cyc_t cyc_ff, nxt_cyc;
  lvm_slv_t slv_ff, nxt_slv;
  logic warn_ff, nxt_warn;

  // one segment hit: upper halfword between start (low half) and end (high half)
  function automatic logic seg_hit(input logic [31:0] se, input logic [31:0] a);
    seg_hit = (a[31:16] >= se[15:0]) && (a[31:16] <= se[31:16]);
  endfunction

  // attribute byte of decoder n, decoder four in bits 31..24
  function automatic logic [7:0] attr_byte(input logic [31:0] w, input int n);
    attr_byte = w[8*n +: 8];
  endfunction

  // modifier code from space, privilege and program flags
  function automatic logic [5:0] am_pick(input logic a24, input logic sup, input logic prg);
    logic [5:0] r;
    r = a24 ? (sup ? (prg ? LVM_AM_A24_SP : LVM_AM_A24_SD)
                   : (prg ? LVM_AM_A24_UP : LVM_AM_A24_UD))
            : (sup ? (prg ? LVM_AM_A32_SP : LVM_AM_A32_SD)
                   : (prg ? LVM_AM_A32_UP : LVM_AM_A32_UD));
    am_pick = r;
  endfunction

  // register decode
  wire wr_ctrl = reg_wr && (reg_addr == LVM_OFS_CTRL);
  wire wr_attr = reg_wr && (reg_addr == LVM_OFS_ATTR);
  wire wr_xlat = reg_wr && (reg_addr == LVM_OFS_XLAT4);
  wire [3:0] wr_se;
  assign wr_se[0] = reg_wr && (reg_addr == LVM_OFS_START1);
  assign wr_se[1] = reg_wr && (reg_addr == LVM_OFS_START2);
  assign wr_se[2] = reg_wr && (reg_addr == LVM_OFS_START3);
  assign wr_se[3] = reg_wr && (reg_addr == LVM_OFS_START4);
  wire [31:0] ctrl_word = {grp_ff, brd_ff, en_ff, io_ff, 8'h00};

  // writes store the value, reads return it the next cycle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      nxt_start_end[i] = wr_se[i] ? reg_wdata : start_end_ff[i];
    end
    nxt_xlat = wr_xlat ? reg_wdata : xlat_ff;
    nxt_attr = wr_attr ? reg_wdata : attr_ff;
    nxt_grp = wr_ctrl ? reg_wdata[LVM_GRP_LSB +: 8] : grp_ff;
    nxt_brd = wr_ctrl ? reg_wdata[LVM_BRD_LSB +: 4] : brd_ff;
    nxt_en = wr_ctrl ? reg_wdata[LVM_EN_LSB +: 4] : en_ff;
    nxt_io = wr_ctrl ? reg_wdata[LVM_IO_LSB +: 8] : io_ff;
    case (reg_addr)
      LVM_OFS_START1: nxt_rdata = start_end_ff[0];
      LVM_OFS_START2: nxt_rdata = start_end_ff[1];
      LVM_OFS_START3: nxt_rdata = start_end_ff[2];
      LVM_OFS_START4: nxt_rdata = start_end_ff[3];
      LVM_OFS_XLAT4: nxt_rdata = xlat_ff;
      LVM_OFS_ATTR: nxt_rdata = attr_ff;
      LVM_OFS_CTRL: nxt_rdata = ctrl_word;
      default: nxt_rdata = 32'h0000_0000; // unmapped reads zero
    endcase
    if (!reg_rd) begin
      nxt_rdata = 32'h0000_0000;
    end
  end

  // warning flag: software moved group/board of a live decoder without owning the bus
  wire csr_live = (brd_ff != LVM_BRD_OFF);
  wire csr_move = wr_ctrl && ((reg_wdata[LVM_GRP_LSB +: 8] != grp_ff)
                  || (reg_wdata[LVM_BRD_LSB +: 4] != brd_ff));
  assign nxt_warn = csr_live && csr_move && !vme_owned;

  // programmable decoder claims, gated by enables
  wire [31:0] la = local_req.addr;
  wire [3:0] prog_hit;
  assign prog_hit[0] = en_ff[0] && seg_hit(start_end_ff[0], la);
  assign prog_hit[1] = en_ff[1] && seg_hit(start_end_ff[1], la);
  assign prog_hit[2] = en_ff[2] && seg_hit(start_end_ff[2], la);
  assign prog_hit[3] = en_ff[3] && seg_hit(start_end_ff[3], la);

  // fixed windows
  wire ss_hit = io_ff[LVM_SS_ON - LVM_IO_LSB] && (la[31:16] == LVM_SS_PAGE);
  // only the upper half of page FF is left out; its lower half still belongs to the f-page
  wire fp_range = (la[31:28] == LVM_FP_NIB) && (la[31:23] != {LVM_FP_TOP, 1'b1});
  wire fp_hit = io_ff[LVM_FP_ON - LVM_IO_LSB] && fp_range;
  wire fp_a24 = (la[31:24] == LVM_FP_A24);

  // exactly-one claim check
  wire [5:0] all_hit = {fp_hit, ss_hit, prog_hit};
  wire one_hit = (all_hit != 6'h00) && ((all_hit & (all_hit - 6'h01)) == 6'h00);
  wire many_hit = (all_hit != 6'h00) && !one_hit;

  // decoder four translation: select bits take the translation address
  wire [15:0] x_sel = xlat_ff[15:0];
  wire [15:0] x_adr = xlat_ff[31:16];
  wire [31:0] xl_addr = {(x_adr & x_sel) | (la[31:16] & ~x_sel), la[15:0]};

  // attribute selection for the one claiming decoder
  wire ss_sup = io_ff[LVM_SS_PRIV - LVM_IO_LSB];
  wire fp_sup = io_ff[LVM_FP_PRIV - LVM_IO_LSB];
  wire fp_prg = io_ff[LVM_FP_PD - LVM_IO_LSB];
  always_comb begin
    logic [7:0] ab;
    ab = 8'h00;
    nxt_cyc = '0;
    nxt_cyc.conflict = local_req.valid && many_hit;
    nxt_cyc.vme_addr = la;
    if (local_req.valid && one_hit) begin
      nxt_cyc.go = 1'b1;
      if (ss_hit) begin
        nxt_cyc.modifier_code_field = ss_sup ? LVM_AM_A16_SUP : LVM_AM_A16_USR;
        nxt_cyc.narrow = io_ff[LVM_SS_NARROW - LVM_IO_LSB];
        nxt_cyc.posted = local_req.write && io_ff[LVM_SS_POST - LVM_IO_LSB];
        nxt_cyc.vme_addr = {16'h0000, la[15:0]};
      end else if (fp_hit) begin
        nxt_cyc.modifier_code_field = am_pick(fp_a24, fp_sup, fp_prg);
        nxt_cyc.narrow = 1'b1;
        nxt_cyc.posted = local_req.write && io_ff[LVM_FP_POST - LVM_IO_LSB];
        nxt_cyc.vme_addr = fp_a24 ? {8'h00, la[23:0]} : la;
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (prog_hit[i]) begin
            ab = attr_byte(attr_ff, i);
          end
        end
        nxt_cyc.modifier_code_field = ab[5:0];
        nxt_cyc.narrow = ab[LVM_ATTR_NARROW];
        nxt_cyc.posted = local_req.write && ab[LVM_ATTR_POST];
        if (prog_hit[3]) begin
          nxt_cyc.vme_addr = xl_addr;
        end
      end
    end
  end

  // vme slave side: status block and location monitor decode
  wire grp_match = (vme_slv_addr[15:8] == grp_ff);
  wire lm_zone = vme_slv_short && grp_match && (vme_slv_addr[7:4] == LVM_LM_NIB);
  always_comb begin
    nxt_slv = '0;
    // board nibble compare; all-ones board leaves the decoder off
    nxt_slv.csr_hit = vme_slv_short && grp_match && csr_live
                      && (vme_slv_addr[7:4] == brd_ff);
    // odd low nibbles 1,3,5,7 select monitors zero..three
    if (lm_zone && vme_slv_addr[0] && !vme_slv_addr[3]) begin
      nxt_slv.lm_hit[vme_slv_addr[2:1]] = 1'b1;
    end
  end

  // state registers; reset values per field
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        start_end_ff[i] <= LVM_MAP_RST;
      end
      xlat_ff <= LVM_MAP_RST;
      attr_ff <= LVM_ATTR_RST;
      grp_ff <= LVM_GRP_RST;
      brd_ff <= LVM_BRD_RST;
      en_ff <= LVM_EN_RST;
      io_ff <= LVM_IO_RST;
      rdata_ff <= 32'h0000_0000;
      cyc_ff <= '0;
      slv_ff <= '0;
      warn_ff <= 1'b0;
    end else begin
      start_end_ff <= nxt_start_end;
      xlat_ff <= nxt_xlat;
      attr_ff <= nxt_attr;
      grp_ff <= nxt_grp;
      brd_ff <= nxt_brd;
      en_ff <= nxt_en;
      io_ff <= nxt_io;
      rdata_ff <= nxt_rdata;
      cyc_ff <= nxt_cyc;
      slv_ff <= nxt_slv;
      warn_ff <= nxt_warn;
    end
  end

  // outputs all come from flip-flops
  assign reg_rdata = rdata_ff;
  assign vme_cyc = cyc_ff;
  assign slv_dec = slv_ff;
  assign ctrl_change_unowned = warn_ff;
endmodule
`default_nettype wire

/* File: dv/lvm_map_checker.sv */
// assertion checker for the local-to-vme map block
`timescale 1ns/10ps
`default_nettype none
module lvm_map_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // map path
  input wire lvm_pkg::lvm_req_t local_req,
  input wire lvm_pkg::lvm_cyc_t vme_cyc,
  // slave decode
  input wire logic [15:0] vme_slv_addr,
  input wire logic vme_slv_short,
  input wire logic vme_owned,
  input wire lvm_pkg::lvm_slv_t slv_dec,
  input wire logic ctrl_change_unowned
);
  import lvm_pkg::*;
  logic [31:0] addr_ff;
  logic [15:0] slv_ff;
  logic short_ff;
  logic [7:0] io_sh;
  logic [7:0] io_prev;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_b);
  // inputs of the previous cycle, since both registered outputs answer one cycle late
  always_ff @(posedge clock) begin
    addr_ff <= local_req.addr;
    slv_ff <= vme_slv_addr;
    short_ff <= vme_slv_short;
    // shadow of the i/o control byte; io_prev lines up with the registered answer
    if (!rst_b) begin
      io_sh <= LVM_IO_RST;
    end else if (reg_wr && reg_addr == LVM_OFS_CTRL) begin
      io_sh <= reg_wdata[LVM_IO_LSB +: 8];
    end
    io_prev <= io_sh;
  end
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside the read answer cycle");
  AST_NO_REQ_NO_GO: assert property (!$past(local_req.valid) |-> !vme_cyc.go)
    else $error("cycle forwarded without a local request");
  AST_CONFLICT: assert property (vme_cyc.conflict |-> !vme_cyc.go)
    else $error("cycle forwarded despite a decoder conflict");
  AST_READ_NOT_POSTED: assert property (vme_cyc.go && !$past(local_req.write) |-> !vme_cyc.posted)
    else $error("read marked as posted");
  AST_SS_ADDR: assert property (vme_cyc.go && io_prev[LVM_SS_ON - LVM_IO_LSB]
    && addr_ff[31:16] == LVM_SS_PAGE
    |-> vme_cyc.vme_addr == {16'h0000, addr_ff[15:0]})
    else $error("short space address not mapped to its low half");
  AST_FP_NARROW: assert property (vme_cyc.go && io_prev[LVM_FP_ON - LVM_IO_LSB]
    && addr_ff[31:28] == LVM_FP_NIB
    && addr_ff[31:23] != {LVM_FP_TOP, 1'b1} |-> vme_cyc.narrow)
    else $error("f-page cycle not narrow");
  AST_CSR_HIT: assert property (slv_dec.csr_hit |-> short_ff && slv_ff[7:4] != LVM_BRD_OFF)
    else $error("status block hit outside short space or on reserved board nibble");
  AST_LM_HIT: assert property (|slv_dec.lm_hit |-> short_ff && slv_ff[7:4] == LVM_LM_NIB
    && $onehot(slv_dec.lm_hit))
    else $error("location monitor hit on a wrong address");
  AST_PULSE: assert property (ctrl_change_unowned |-> $past(reg_wr)
    && $past(reg_addr) == LVM_OFS_CTRL && !$past(vme_owned))
    else $error("ownership flag without an unowned control write");
  COV_GO: cover property (vme_cyc.go);
  COV_CONFLICT: cover property (vme_cyc.conflict);
  COV_CSR: cover property (slv_dec.csr_hit);
  COV_LM: cover property (slv_dec.lm_hit[3]);
endmodule
`default_nettype wire

/* File: dv/lvm_vme_slave.sv */
// far-side slave board model: counts the cycles the map forwards to it
`timescale 1ns/10ps
`default_nettype none
module lvm_vme_slave (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // forwarded cycle and count of accepted ones
  input wire lvm_pkg::lvm_cyc_t cyc,
  output var int n_go
);
  import lvm_pkg::*;
  // a conflicting claim must never reach the bus, so it is not counted
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      n_go <= 0;
    end else if (cyc.go && !cyc.conflict) begin
      n_go <= n_go + 1;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the local-to-vme map block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lvm_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  lvm_req_t local_req = '0;
  lvm_cyc_t vme_cyc;
  logic [15:0] vme_slv_addr = 16'h0000;
  logic vme_slv_short = 1'b0;
  logic vme_owned = 1'b1;
  lvm_slv_t slv_dec;
  logic ctrl_change_unowned;
  logic [31:0] f;
  int n_go;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  always #2.5 clock = ~clock;
  lvm_map dut_u (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .local_req(local_req),
    .vme_cyc(vme_cyc), .vme_slv_addr(vme_slv_addr), .vme_slv_short(vme_slv_short),
    .vme_owned(vme_owned), .slv_dec(slv_dec), .ctrl_change_unowned(ctrl_change_unowned));
  lvm_vme_slave far_u (.clock(clock), .rst_b(rst_b), .cyc(vme_cyc), .n_go(n_go));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // f holds go, modifier, narrow and posted of the answer
  task automatic acc(input logic [31:0] a, input logic w);
    @(posedge clock);
    local_req <= '{valid: 1'b1, write: w, addr: a};
    @(posedge clock);
    local_req.valid <= 1'b0;
    #1 f = {23'h0, vme_cyc[41:33]};
  endtask
  // released address lines are scrambled so a stale value cannot match
  task automatic slv(input logic [15:0] a, input logic [4:0] e);
    @(posedge clock);
    vme_slv_addr <= a;
    vme_slv_short <= 1'b1;
    @(posedge clock);
    vme_slv_short <= 1'b0;
    vme_slv_addr <= ~a;
    #1 chk({27'h0, slv_dec}, {27'h0, e});
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    rd(LVM_OFS_ATTR, LVM_ATTR_RST);
    rd(LVM_OFS_CTRL, 32'h00F0_0000);
    rd(8'h40, 32'h0);
    // programmable decoders; no block-transfer modifier is ever loaded
    wr(LVM_OFS_START1, 32'h1FFF_1000);
    wr(LVM_OFS_START2, 32'h1FFF_1000);
    wr(LVM_OFS_ATTR, 32'h0000_49BD);
    rd(LVM_OFS_ATTR, 32'h0000_49BD);
    acc(32'h1000_0040, 1'b1);
    chk(f, 32'h0);
    wr(LVM_OFS_CTRL, 32'h00F1_0000);
    acc(32'h1000_0040, 1'b1);
    chk(f, {23'h0, 1'b1, LVM_AM_A24_SD, 2'b10});
    wr(LVM_OFS_CTRL, 32'h00F2_0000);
    acc(32'h1FFF_FFFC, 1'b1);
    chk(f, {23'h0, 1'b1, LVM_AM_A32_UD, 2'b01});
    wr(LVM_OFS_CTRL, 32'h00F3_0000);
    acc(32'h1800_0000, 1'b0);
    chk({f[30:0], vme_cyc.conflict}, 32'h1);
    // short space window
    wr(LVM_OFS_CTRL, 32'h00F0_0F00);
    acc(32'hFFFF_1234, 1'b1);
    chk(f, {23'h0, 1'b1, LVM_AM_A16_SUP, 2'b11});
    chk(vme_cyc.vme_addr, 32'h0000_1234);
    wr(LVM_OFS_CTRL, 32'h00F0_0A00);
    acc(32'hFFFF_0010, 1'b1);
    chk(f, {23'h0, 1'b1, LVM_AM_A16_USR, 2'b01});
    wr(LVM_OFS_CTRL, 32'h00F0_0700);
    acc(32'hFFFF_0010, 1'b0);
    chk(f, 32'h0);
    // f-page window
    wr(LVM_OFS_CTRL, 32'h00F0_B000);
    acc(32'hF012_3456, 1'b1);
    chk(f, {23'h0, 1'b1, LVM_AM_A24_SP, 2'b10});
    chk(vme_cyc.vme_addr, 32'h0012_3456);
    wr(LVM_OFS_CTRL, 32'h00F0_C000);
    acc(32'hFE00_0000, 1'b1);
    chk(f, {23'h0, 1'b1, LVM_AM_A32_UD, 2'b11});
    acc(32'hFF80_0000, 1'b0);
    chk(f, 32'h0);
    acc(32'hFF10_0000, 1'b0);
    chk(f, {23'h0, 1'b1, LVM_AM_A32_UD, 2'b10});
    // decoder four: upper address byte comes from the translation register
    wr(LVM_OFS_START4, 32'h2FFF_2000);
    wr(LVM_OFS_XLAT4, 32'hAB00_FF00);
    rd(LVM_OFS_XLAT4, 32'hAB00_FF00);
    wr(LVM_OFS_ATTR, 32'h3900_49BD);
    wr(LVM_OFS_CTRL, 32'h00F8_0000);
    acc(32'h2345_6789, 1'b0);
    chk(f, {23'h0, 1'b1, LVM_AM_A24_UD, 2'b00});
    chk(vme_cyc.vme_addr, 32'hAB45_6789);
    // status block and location monitors on the slave side
    wr(LVM_OFS_CTRL, 32'h1230_0000);
    slv(16'h1230, 5'h10);
    slv(16'h1330, 5'h00);
    for (int i = 0; i < 4; i++) begin
      slv(16'h12F1 + 16'(2 * i), 5'(1 << i));
    end
    @(posedge clock);
    vme_owned <= 1'b0;
    wr(LVM_OFS_CTRL, 32'h12F0_0000);
    #1 chk(32'(ctrl_change_unowned), 32'h1);
    slv(16'h1230, 5'h00);
    chk(32'(n_go), 32'h8);
    summarize();
  end
  // hang guard, far above the hundred or so cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
endmodule
bind lvm_map lvm_map_checker chk_u (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .local_req(local_req), .vme_cyc(vme_cyc), .vme_slv_addr(vme_slv_addr),
  .vme_slv_short(vme_slv_short), .vme_owned(vme_owned), .slv_dec(slv_dec),
  .ctrl_change_unowned(ctrl_change_unowned));
`default_nettype wire
